// [verilog/cpu_ctl_pkg.sv]
// Package: constants, types and register map of the control/wide-add core
package cpu_ctl_pkg;

	// ====================================================================
	// Register map (byte addresses, one aligned 32-bit word each)
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] FLAGS_OFS  = 8'h08;
	localparam logic [7:0] HL_OFS     = 8'h0C;
	localparam logic [7:0] BC_OFS     = 8'h10;
	localparam logic [7:0] DE_OFS     = 8'h14;
	localparam logic [7:0] SP_OFS     = 8'h18;
	localparam logic [7:0] IPAGE_OFS  = 8'h1C;
	localparam logic [7:0] PC_OFS     = 8'h20;

	// Field positions and reset values
	localparam int          CTRL_RUN_BIT = 0;
	localparam logic [7:0]  FLAGS_RST    = 8'h00;
	localparam logic [15:0] PAIR_RST     = 16'h0000;
	localparam logic [7:0]  IPAGE_RST    = 8'h00;
	localparam logic [1:0]  MODE_RST     = 2'h0;
	localparam logic        RUN_RST      = 1'b0;

	// ====================================================================
	// Opcodes
	localparam logic [7:0] OP_CARRY_CPL = 8'h3F;
	localparam logic [7:0] OP_CARRY_SET = 8'h37;
	localparam logic [7:0] OP_IDLE      = 8'h00;
	localparam logic [7:0] OP_SUSPEND   = 8'h76;
	localparam logic [7:0] OP_IRQ_OFF   = 8'hF3;
	localparam logic [7:0] OP_IRQ_ON    = 8'hFB;
	localparam logic [7:0] OP_PREFIX    = 8'hED;
	localparam logic [7:0] OP_MODE0     = 8'h46;
	localparam logic [7:0] OP_MODE1     = 8'h56;
	localparam logic [7:0] OP_MODE2     = 8'h5E;
	localparam logic [7:0] PAIR_MASK    = 8'hCF;
	localparam logic [7:0] OP_ADD_PAT   = 8'h09;
	localparam logic [7:0] OP_ADC_PAT   = 8'h4A;

	// Interrupt modes and the fixed restart target
	localparam logic [1:0]  MODE_0      = 2'h0;
	localparam logic [1:0]  MODE_1      = 2'h1;
	localparam logic [1:0]  MODE_2      = 2'h2;
	localparam logic [15:0] RESTART_ADR = 16'h0038;

	// ====================================================================
	// Timing: one T state is one core_clk cycle (4 ns)
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         T_M1          = 4;
	localparam int         T_ADD         = 11;
	localparam int         T_ADC         = 15;
	localparam logic [3:0] EXTRA_ADD     = 4'(T_ADD - T_M1);
	localparam logic [3:0] EXTRA_ADC     = 4'(T_ADC - 2 * T_M1);
	localparam logic [3:0] M1_LAST       = 4'(T_M1 - 2);

	// ====================================================================
	// Types
	typedef enum logic [2:0] {
		ST_M1    = 3'b000,
		ST_DEC   = 3'b001,
		ST_EXTRA = 3'b010,
		ST_ACK   = 3'b011,
		ST_TBL   = 3'b100
	} state_e;

	typedef struct packed {
		logic s;
		logic z;
		logic b5;
		logic h;
		logic b3;
		logic pv;
		logic n;
		logic c;
	} flags_s;

	typedef struct packed {
		logic [15:0] sum;
		logic        h;
		logic        c;
		logic        v;
	} add_res_s;

endpackage

// [verilog/wide_adder.sv]
// Sixteen-bit adder with carry-in giving half-carry, carry and overflow
`timescale 1ns/1ns
module wide_adder
	import cpu_ctl_pkg::*;
(
	// Operands
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	input  wire logic        cin,
	// Result
	output add_res_s         res
);

	logic [12:0] low_sum;
	logic [16:0] full_sum;

	always_comb begin
		low_sum  = {1'b0, a[11:0]} + {1'b0, b[11:0]} + {12'h000, cin};
		full_sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
		res.sum  = full_sum[15:0];
		res.h    = low_sum[12];
		res.c    = full_sum[16];
		res.v    = (a[15] == b[15]) && (full_sum[15] != a[15]);
	end

endmodule // wide_adder

// [verilog/cpu_ctl_core.sv]
// Control-instruction and wide-add execution core with APB register access
//
// Functional notes
// - Opcode 3F inverts carry, clears subtract, keeps S Z PV, four T states.
// - Carry complement copies the old carry into half-carry.
// - Opcode 37 sets carry, clears half-carry and subtract, four T states.
// - Opcode 00 changes nothing and takes four T states.
// - Opcode 76 suspends until an interrupt is taken or reset.
// - While suspended, idle cycles keep running for refresh.
// - Opcode F3 clears both enable flip-flops, masking at once.
// - With enables clear, the interrupt request is ignored.
// - Opcode FB sets both enable flip-flops.
// - No interrupt during the enable opcode or the next instruction.
// - ED 46 selects mode 0; peripheral supplies an instruction.
// - Mode 0 takes the first byte at acknowledge, rest from memory.
// - ED 56 selects mode 1; interrupts restart at 0038h.
// - Mode 2 reads the routine address at page:vector from memory.
// - 00ss1001 adds pair into the wide accumulator, eleven T states.
// - Plain wide add: H from bit 11, C from bit 15, N cleared.
// - ED 01ss1010 adds pair plus carry, fifteen T states.
// - Add with carry also sets S, Z and overflow into PV.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
module cpu_ctl_core
	import cpu_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Memory read port
	output logic             mem_rd_req,
	output logic      [15:0] mem_rd_addr,
	input  wire logic [7:0]  mem_rd_data,
	input  wire logic        mem_rd_valid,
	// Interrupt request pin and acknowledge
	input  wire logic        irq_req_n,
	output logic             ack_req,
	input  wire logic [7:0]  ack_data,
	input  wire logic        ack_valid,
	// Status
	output logic             halted
);

	// ====================================================================
	// State
	state_e      state;
	logic [3:0]  tcnt;
	logic [7:0]  op;
	logic        got;
	logic        ed_pend;
	logic        irq_enable_ff_primary;
	logic        irq_enable_ff_shadow;
	logic        ei_hold;
	logic [1:0]  mode;
	flags_s      flags;
	logic [15:0] wide_accumulator_pair;
	logic [15:0] bc;
	logic [15:0] de;
	logic [15:0] sp;
	logic [7:0]  ipage;
	logic [15:0] pc;
	logic        run;
	logic [1:0]  tbl_step;
	logic        irq_meta;
	logic        irq_sync;
	logic        irq_take;
	logic        apb_wr;
	logic        rd_hit;
	add_res_s    add_res;

	// ====================================================================
	// Helpers
	function automatic logic mapped(input logic [7:0] adr);
		return adr == CTRL_OFS || adr == STATUS_OFS || adr == FLAGS_OFS ||
			adr == HL_OFS || adr == BC_OFS || adr == DE_OFS ||
			adr == SP_OFS || adr == IPAGE_OFS || adr == PC_OFS;
	endfunction

	function automatic logic [15:0] pair_val(input logic [1:0] ss);
		unique case (ss)
			2'h0: return bc;
			2'h1: return de;
			2'h2: return wide_accumulator_pair;
			2'h3: return sp;
		endcase
	endfunction

	function automatic logic [31:0] read_reg(input logic [7:0] adr);
		unique case (adr)
			CTRL_OFS:   return {31'h0, run};
			STATUS_OFS: return {26'h0, ei_hold, halted,
				irq_enable_ff_shadow, irq_enable_ff_primary, mode};
			FLAGS_OFS:  return {24'h0, flags};
			HL_OFS:     return {16'h0, wide_accumulator_pair};
			BC_OFS:     return {16'h0, bc};
			DE_OFS:     return {16'h0, de};
			SP_OFS:     return {16'h0, sp};
			IPAGE_OFS:  return {24'h0, ipage};
			PC_OFS:     return {16'h0, pc};
			default:    return 32'h0;
		endcase
	endfunction

	// ====================================================================
	// APB answer: one wait-free access phase, data registered in setup
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			prdata  <= read_reg(paddr);
			pslverr <= !mapped(paddr);
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	assign apb_wr = psel && penable && pready && pwrite && mapped(paddr);
	assign rd_hit = mem_rd_req && mem_rd_valid;

	// ====================================================================
	// Interrupt pin synchroniser
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_meta <= 1'b1;
			irq_sync <= 1'b1;
		end else begin
			irq_meta <= irq_req_n;
			irq_sync <= irq_meta;
		end
	end

	// Request seen only with enables set and outside the enable shadow
	assign irq_take = run && !irq_sync && irq_enable_ff_primary &&
		!ei_hold && !ed_pend;

	wide_adder u_adder (
		.a   (wide_accumulator_pair),
		.b   (pair_val(op[5:4])),
		.cin (ed_pend & flags.c),
		.res (add_res)
	);

	// ====================================================================
	// Sequencer and architectural registers. A software write wins over
	// the hardware update in the same cycle, so stop the core first.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state                 <= ST_M1;
			tcnt                  <= 4'h0;
			op                    <= OP_IDLE;
			got                   <= 1'b0;
			ed_pend               <= 1'b0;
			halted                <= 1'b0;
			irq_enable_ff_primary <= 1'b0;
			irq_enable_ff_shadow  <= 1'b0;
			ei_hold               <= 1'b0;
			mode                  <= MODE_RST;
			flags                 <= FLAGS_RST;
			wide_accumulator_pair <= PAIR_RST;
			bc                    <= PAIR_RST;
			de                    <= PAIR_RST;
			sp                    <= PAIR_RST;
			ipage                 <= IPAGE_RST;
			pc                    <= PAIR_RST;
			run                   <= RUN_RST;
			tbl_step              <= 2'h0;
			mem_rd_req            <= 1'b0;
			mem_rd_addr           <= PAIR_RST;
			ack_req               <= 1'b0;
		end else if (apb_wr) begin
			unique case (paddr)
				CTRL_OFS:  run <= pwdata[CTRL_RUN_BIT];
				FLAGS_OFS: flags <= pwdata[7:0];
				HL_OFS:    wide_accumulator_pair <= pwdata[15:0];
				BC_OFS:    bc <= pwdata[15:0];
				DE_OFS:    de <= pwdata[15:0];
				SP_OFS:    sp <= pwdata[15:0];
				IPAGE_OFS: ipage <= pwdata[7:0];
				PC_OFS:    pc <= pwdata[15:0];
				default:   ;
			endcase
		end else begin
			unique case (state)
				ST_M1: begin
					if (tcnt == 4'h0) begin
						if (irq_take) begin
							state                 <= ST_ACK;
							ack_req               <= 1'b1;
							halted                <= 1'b0;
							irq_enable_ff_primary <= 1'b0;
							irq_enable_ff_shadow  <= 1'b0;
						end else if (run) begin
							tcnt <= 4'h1;
							// Suspended: no fetch, just idle cycles
							if (!halted) begin
								mem_rd_req  <= 1'b1;
								mem_rd_addr <= pc;
								pc          <= pc + 16'h0001;
							end
						end
					end else begin
						if (rd_hit) begin
							mem_rd_req <= 1'b0;
							got        <= 1'b1;
							op         <= mem_rd_data;
						end
						if (tcnt == M1_LAST) begin
							if (halted) begin
								op    <= OP_IDLE;
								state <= ST_DEC;
							end else if (got || rd_hit) begin
								state <= ST_DEC;
							end
						end else begin
							tcnt <= tcnt + 4'h1;
						end
					end
				end
				ST_DEC: begin
					got   <= 1'b0;
					tcnt  <= 4'h0;
					state <= ST_M1;
					ei_hold <= 1'b0;
					if (ed_pend) begin
						ed_pend <= 1'b0;
						if (op == OP_MODE0) begin
							mode <= MODE_0;
						end else if (op == OP_MODE1) begin
							mode <= MODE_1;
						end else if (op == OP_MODE2) begin
							mode <= MODE_2;
						end else if ((op & PAIR_MASK) == OP_ADC_PAT) begin
							wide_accumulator_pair <= add_res.sum;
							flags.s  <= add_res.sum[15];
							flags.z  <= add_res.sum == 16'h0000;
							flags.h  <= add_res.h;
							flags.pv <= add_res.v;
							flags.n  <= 1'b0;
							flags.c  <= add_res.c;
							state    <= ST_EXTRA;
							tcnt     <= EXTRA_ADC - 4'h1;
						end
					end else if (op == OP_CARRY_CPL) begin
						flags.h <= flags.c;
						flags.c <= !flags.c;
						flags.n <= 1'b0;
					end else if (op == OP_CARRY_SET) begin
						flags.c <= 1'b1;
						flags.h <= 1'b0;
						flags.n <= 1'b0;
					end else if (op == OP_SUSPEND) begin
						halted <= 1'b1;
					end else if (op == OP_IRQ_OFF) begin
						irq_enable_ff_primary <= 1'b0;
						irq_enable_ff_shadow  <= 1'b0;
					end else if (op == OP_IRQ_ON) begin
						irq_enable_ff_primary <= 1'b1;
						irq_enable_ff_shadow  <= 1'b1;
						ei_hold               <= 1'b1;
					end else if (op == OP_PREFIX) begin
						ed_pend <= 1'b1;
						ei_hold <= ei_hold;
					end else if ((op & PAIR_MASK) == OP_ADD_PAT) begin
						wide_accumulator_pair <= add_res.sum;
						flags.h <= add_res.h;
						flags.c <= add_res.c;
						flags.n <= 1'b0;
						state   <= ST_EXTRA;
						tcnt    <= EXTRA_ADD - 4'h1;
					end
					// Any other opcode, including 00, passes as idle
				end
				ST_EXTRA: begin
					if (tcnt == 4'h0) begin
						state <= ST_M1;
					end else begin
						tcnt <= tcnt - 4'h1;
					end
				end
				ST_ACK: begin
					if (ack_valid) begin
						ack_req <= 1'b0;
						if (mode == MODE_0) begin
							op    <= ack_data;
							state <= ST_DEC;
						end else if (mode == MODE_1) begin
							pc    <= RESTART_ADR;
							tcnt  <= 4'h0;
							state <= ST_M1;
						end else begin
							mem_rd_req  <= 1'b1;
							mem_rd_addr <= {ipage, ack_data};
							tbl_step    <= 2'h0;
							state       <= ST_TBL;
						end
					end
				end
				ST_TBL: begin
					// Low byte, one idle cycle, then high byte
					unique case (tbl_step)
						2'h0: if (rd_hit) begin
							pc[7:0]    <= mem_rd_data;
							mem_rd_req <= 1'b0;
							tbl_step   <= 2'h1;
						end
						2'h1: begin
							mem_rd_req  <= 1'b1;
							mem_rd_addr <= mem_rd_addr + 16'h0001;
							tbl_step    <= 2'h2;
						end
						2'h2: if (rd_hit) begin
							pc[15:8]   <= mem_rd_data;
							mem_rd_req <= 1'b0;
							tbl_step   <= 2'h0;
							tcnt       <= 4'h0;
							state      <= ST_M1;
						end
						default: tbl_step <= 2'h0;
					endcase
				end
				default: state <= ST_M1;
			endcase
		end
	end

	// ====================================================================
	// Checks
	logic dec_plain;
	assign dec_plain = state == ST_DEC && !ed_pend && !apb_wr;

	ccf_flip_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && op == OP_CARRY_CPL |=> flags.c == !$past(flags.c) &&
		!flags.n && flags.s == $past(flags.s) && flags.pv == $past(flags.pv))
		else $error("carry complement wrong");

	ccf_half_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && op == OP_CARRY_CPL |=> flags.h == $past(flags.c))
		else $error("half-carry not old carry");

	scf_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && op == OP_CARRY_SET |=> flags.c && !flags.h && !flags.n)
		else $error("carry set wrong");

	idle_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && op == OP_IDLE |=> $stable(flags) &&
		$stable(wide_accumulator_pair) && state == ST_M1)
		else $error("idle opcode changed state");

	suspend_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		halted && state == ST_DEC && !apb_wr |=> halted)
		else $error("left suspend without interrupt");

	suspend_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		halted && state == ST_M1 && tcnt == 4'h0 && run && !irq_take &&
		!apb_wr |-> ##3 state == ST_DEC && !mem_rd_req)
		else $error("suspended idle cycle broken");

	irq_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && op == OP_IRQ_OFF |=> !irq_enable_ff_primary &&
		!irq_enable_ff_shadow)
		else $error("enables not cleared");

	irq_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == ST_M1 && !irq_enable_ff_primary |=> state != ST_ACK)
		else $error("masked request accepted");

	irq_on_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && op == OP_IRQ_ON |=> irq_enable_ff_primary &&
		irq_enable_ff_shadow && ei_hold)
		else $error("enables not set");

	ei_shadow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == ST_M1 && ei_hold |=> state != ST_ACK)
		else $error("interrupt inside enable shadow");

	mode1_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == ST_ACK && ack_valid && mode == MODE_1 |=> pc == RESTART_ADR)
		else $error("mode 1 target wrong");

	add_sum_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		dec_plain && (op & PAIR_MASK) == OP_ADD_PAT |=>
		wide_accumulator_pair == $past(add_res.sum) && flags.c ==
		$past(add_res.c) && state == ST_EXTRA ##7 state == ST_M1)
		else $error("wide add wrong");

	mode_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$changed(mode) |-> $past(state) == ST_DEC && $past(ed_pend))
		else $error("mode changed outside select");

endmodule // cpu_ctl_core

// [testbench/irq_peer.sv]
// Far-side model: program memory and the interrupting peripheral
`timescale 1ns/1ns
module irq_peer (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Memory read port
	input  wire logic        mem_rd_req,
	input  wire logic [15:0] mem_rd_addr,
	output logic      [7:0]  mem_rd_data,
	output logic             mem_rd_valid,
	// Interrupt acknowledge
	input  wire logic        ack_req,
	output logic      [7:0]  ack_data,
	output logic             ack_valid
);
	// ====================================================================
	// Answer delay and supplied byte, set by the bench between runs
	int         lat = 0;
	logic [7:0] vec = 8'h00;
	logic [7:0] mem [0:65535];
	int         wcnt;
	logic [7:0] last_m = 8'h00;
	logic [7:0] last_a = 8'h00;

	initial foreach (mem[i]) mem[i] = 8'h00;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			wcnt <= 0;
		else if ((mem_rd_req && !mem_rd_valid) || (ack_req && !ack_valid))
			wcnt <= wcnt + 1;
		else
			wcnt <= 0;
	end

	assign mem_rd_valid = mem_rd_req && (wcnt >= lat);
	assign ack_valid    = ack_req && (wcnt >= lat);
	// Released bus shows the inverse of the last byte, never a held copy
	assign mem_rd_data  = mem_rd_valid ? mem[mem_rd_addr] : ~last_m;
	assign ack_data     = ack_valid ? vec : ~last_a;

	always_ff @(posedge core_clk) begin
		if (mem_rd_valid)
			last_m <= mem[mem_rd_addr];
		if (ack_valid)
			last_a <= vec;
	end
endmodule // irq_peer

// [testbench/testbench.sv]
// Self-checking bench for the control and wide-add core
`timescale 1ns/1ns
module testbench
	import cpu_ctl_pkg::*;
;
	// ====================================================================
	// Signals and bench state
	logic        core_clk = 1'b0, arst_n = 1'b0, irq_req_n = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'hE68E;
	logic        pready, pslverr, err, halted;
	logic        mem_rd_req, mem_rd_valid, ack_req, ack_valid;
	logic [15:0] mem_rd_addr, hl, bc, de, sp, x, ehl;
	logic [7:0]  mem_rd_data, ack_data, f, ef, prog[$];
	logic [16:0] r;
	logic [12:0] t;
	logic [1:0]  em;
	logic        ie, ci;
	int          n_errors = 0, checks = 0, base, cyc;
	logic [15:0] ops[16] = '{16'h003F, 16'h0037, 16'h0000, 16'h00F3,
		16'h00FB, 16'h0009, 16'h0019, 16'h0029, 16'h0039, 16'hED4A,
		16'hED5A, 16'hED6A, 16'hED7A, 16'hED46, 16'hED56, 16'hED5E};
	int          tst[16] = '{4, 4, 4, 4, 4, 11, 11, 11, 11, 15, 15, 15, 15,
		8, 8, 8};
	logic [7:0]  mbyte[3] = '{8'h46, 8'h56, 8'h5E};
	logic [15:0] epc[3] = '{16'h0005, 16'h0039, 16'h0201};

	always #2 core_clk = ~core_clk;

	cpu_ctl_core dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
		.mem_rd_valid(mem_rd_valid), .irq_req_n(irq_req_n),
		.ack_req(ack_req), .ack_data(ack_data), .ack_valid(ack_valid),
		.halted(halted));

	irq_peer peer_u (.core_clk(core_clk), .arst_n(arst_n),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
		.ack_req(ack_req), .ack_data(ack_data), .ack_valid(ack_valid));

	// ====================================================================
	// Tasks
	task report_and_stop;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Request held until pready is sampled high, then released
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task do_reset;
		arst_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
	endtask

	// Load the program at 0, start the core and count cycles to halt
	task run(output int n);
		foreach (prog[i]) peer_u.mem[i] = prog[i];
		apb(1'b1, CTRL_OFS, 32'h1);
		n = 0;
		while (halted !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	initial begin
		repeat (90000) @(posedge core_clk);
		n_errors++;
		report_and_stop;
	end

	// ====================================================================
	// Main sequence
	initial begin
		peer_u.mem[16'h0038] = OP_SUSPEND;
		peer_u.mem[16'h0200] = OP_SUSPEND;
		peer_u.mem[16'h1235] = 8'h02;
		do_reset;
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status reset", rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		prog = '{OP_SUSPEND};
		run(base);
		// Every opcode kind, random operands, prompt memory
		for (int k = 0; k < 16; k++) begin
			do_reset;
			rnd = lfsr(rnd);
			{hl, bc} = rnd;
			rnd = lfsr(rnd);
			{de, sp} = rnd;
			rnd = lfsr(rnd);
			f = rnd[7:0];
			apb(1'b1, FLAGS_OFS, {24'h0, f});
			apb(1'b1, HL_OFS, {16'h0, hl});
			apb(1'b1, BC_OFS, {16'h0, bc});
			apb(1'b1, DE_OFS, {16'h0, de});
			apb(1'b1, SP_OFS, {16'h0, sp});
			if (ops[k][15:8] == OP_PREFIX)
				prog = '{OP_PREFIX, ops[k][7:0], OP_SUSPEND};
			else
				prog = '{ops[k][7:0], OP_SUSPEND};
			run(cyc);
			x = ops[k][5:4] == 2'h0 ? bc : ops[k][5:4] == 2'h1 ? de :
				ops[k][5:4] == 2'h2 ? hl : sp;
			ef = f;
			ehl = hl;
			ie = (k == 4);
			em = k > 12 ? 2'(k - 13) : MODE_0;
			if (k == 0)
				{ef[4], ef[1], ef[0]} = {f[0], 1'b0, ~f[0]};
			if (k == 1)
				{ef[4], ef[1], ef[0]} = 3'b001;
			if (k >= 5 && k <= 12) begin
				ci = (k > 8) ? f[0] : 1'b0;
				t = {1'b0, hl[11:0]} + {1'b0, x[11:0]} + 13'(ci);
				r = {1'b0, hl} + {1'b0, x} + 17'(ci);
				ehl = r[15:0];
				{ef[4], ef[1], ef[0]} = {t[12], 1'b0, r[16]};
				if (k > 8)
					{ef[7], ef[6], ef[2]} = {r[15], r[15:0] == 16'h0,
						hl[15] == x[15] && r[15] != hl[15]};
			end
			chk("cycles", cyc, base + tst[k]);
			apb(1'b0, HL_OFS, 32'h0);
			chk("hl", rd, {16'h0, ehl});
			apb(1'b0, FLAGS_OFS, 32'h0);
			chk("flags", rd & 32'hD7, {24'h0, ef & 8'hD7});
			apb(1'b0, STATUS_OFS, 32'h0);
			chk("status", rd[3:0], {ie, ie, em});
		end
		// Interrupt in each mode, slow peripheral, accepted after shadow
		for (int m = 0; m < 3; m++) begin
			do_reset;
			peer_u.lat = 2;
			peer_u.vec = m == 0 ? OP_CARRY_CPL : 8'h34;
			apb(1'b1, IPAGE_OFS, 32'h12);
			prog = '{OP_PREFIX, mbyte[m], OP_IRQ_ON, OP_CARRY_CPL, OP_SUSPEND};
			irq_req_n <= 1'b0;
			run(cyc);
			irq_req_n <= 1'b1;
			apb(1'b0, PC_OFS, 32'h0);
			chk("irq pc", rd, {16'h0, epc[m]});
			apb(1'b0, FLAGS_OFS, 32'h0);
			chk("irq carry", rd[0], m != 0);
			apb(1'b0, STATUS_OFS, 32'h0);
			chk("irq status", rd[3:0], 32'(m));
		end
		// Disable right after enable: request ignored, stays suspended
		do_reset;
		peer_u.lat = 0;
		prog = '{OP_IRQ_ON, OP_IRQ_OFF, OP_SUSPEND};
		irq_req_n <= 1'b0;
		run(cyc);
		repeat (40) @(posedge core_clk);
		chk("still halted", halted, 32'h1);
		apb(1'b0, PC_OFS, 32'h0);
		chk("masked pc", rd, 32'h3);
		// Suspended core woken by an accepted interrupt
		do_reset;
		irq_req_n <= 1'b1;
		prog = '{OP_PREFIX, OP_MODE1, OP_IRQ_ON, OP_SUSPEND};
		run(cyc);
		irq_req_n <= 1'b0;
		cyc = 0;
		while (halted === 1'b1 && cyc < 100) begin
			@(posedge core_clk);
			cyc++;
		end
		chk("woken", halted, 32'h0);
		cyc = 0;
		while (halted !== 1'b1 && cyc < 100) begin
			@(posedge core_clk);
			cyc++;
		end
		irq_req_n <= 1'b1;
		apb(1'b0, PC_OFS, 32'h0);
		chk("wake pc", rd, {16'h0, RESTART_ADR + 16'h1});
		report_and_stop;
	end
endmodule // testbench
